// File: ppm_regulator.sv
/*
 process regulator with eight multi-speed presets and feedback-loss detection.
 assumes synchronous inputs, percent values in 0.1 % steps, times in 0.01 s steps
 (loss time in 0.1 s steps), max_frequency in 0.01 Hz steps.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ppm_map.svh"

// What this block does
// - keypad source uses keypad setpoint, clamped to 100 % under code 0; codes 5 to 7 use it unclamped
// - feedback channel chosen by two-bit code
// - positive polarity: feedback high lowers output
// - negative polarity: feedback high raises output
// - gain 100 full error gives maximum
// - integral reaches maximum after one time constant
// - derivative scaled by derivative time constant
// - integral accumulates while discrepancy remains
// - derivative follows discrepancy change only
// - one regulator run per sampling period
// - inside discrepancy limit output holds
// - low feedback timer raises loss fault
// - eight signed presets, negative means reverse
// - hundred percent equals maximum output frequency
// - three terminals form preset index
// - setpoint source chosen by three-bit code
// - regulator works in relative percent
module ppm_regulator #(
	parameter int unsigned TICK_CYCLES = `PPM_TICK_NS / `PPM_CLK_NS
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [2:0] setpoint_source,
	input wire logic [1:0] feedback_source,
	input wire logic output_polarity,
	input wire logic [9:0] keypad_setpoint,
	input wire logic [9:0] voltage_analog_input,
	input wire logic [9:0] current_analog_input,
	input wire logic [9:0] comm_setpoint,
	input wire logic [9:0] comm_feedback,
	input wire logic [13:0] proportional_gain,
	input wire logic [9:0] integral_period_constant,
	input wire logic [9:0] derivative_period_constant,
	input wire logic [13:0] sample_period,
	input wire logic [9:0] discrepancy_limit,
	input wire logic [9:0] loss_threshold,
	input wire logic [15:0] loss_time,
	input wire logic [15:0] max_frequency,
	input wire logic speed_select_bit0,
	input wire logic speed_select_bit1,
	input wire logic speed_select_bit2,
	input wire logic preset_write,
	input wire logic [2:0] preset_index,
	input wire logic [10:0] preset_value,
	input wire logic fault_clear,
	output logic [15:0] freq_command,
	output logic feedback_loss_fault,
	output logic sample_strobe,
	output logic [9:0] preset_level,
	output logic preset_reverse
);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [9:0] sat_pct(input logic [10:0] v);
		sat_pct = (v > {1'b0, `PPM_FULL_PCT}) ? `PPM_FULL_PCT : v[9:0];
	endfunction : sat_pct

	function automatic logic [31:0] abs32(input logic signed [31:0] v);
		abs32 = v[31] ? 32'(-v) : 32'(v);
	endfunction : abs32

	localparam logic [19:0] TICK_LAST = 20'(TICK_CYCLES - 1);

	ppm_pkg::ppm_state_s s;
	ppm_pkg::ppm_state_s n;
	logic [9:0] fb_sel;
	logic [9:0] sp_sel;
	logic [2:0] sel_idx;
	logic signed [11:0] err_now;
	logic signed [11:0] delta;
	logic in_band;
	logic fb_low;
	logic [19:0] loss_lim;
	logic [13:0] per_eff;
	logic [9:0] ti_eff;
	logic tick;
	logic sample;
	logic [16:0] trial;
	logic ge;
	logic [31:0] qn;
	logic signed [31:0] qs;
	logic done;
	logic ld;
	logic signed [31:0] ld_val;
	logic [15:0] ld_dvs;
	logic signed [31:0] isum_new;
	logic signed [31:0] imax;
	logic signed [31:0] sum;

	// ----------------------------------------
	// channel selection
	// ----------------------------------------
	assign sel_idx = {speed_select_bit2, speed_select_bit1, speed_select_bit0};

	always_comb begin
		case (feedback_source)
			2'h0: fb_sel = voltage_analog_input;
			2'h1: fb_sel = current_analog_input;
			2'h2: fb_sel = sat_pct({1'b0, voltage_analog_input} + {1'b0, current_analog_input});
			default: fb_sel = comm_feedback;
		endcase
		case (setpoint_source)
			3'h0: sp_sel = sat_pct({1'b0, keypad_setpoint});
			3'h1: sp_sel = voltage_analog_input;
			3'h2: sp_sel = current_analog_input;
			3'h3: sp_sel = comm_setpoint;
			3'h4: sp_sel = s.prev ? 10'h000 : s.plvl;
			default: sp_sel = keypad_setpoint;
		endcase
	end

	// both channels share the same 0..100 % scale
	assign err_now = output_polarity ?
		($signed({2'h0, fb_sel}) - $signed({2'h0, sp_sel})) :
		($signed({2'h0, sp_sel}) - $signed({2'h0, fb_sel}));
	assign in_band = 12'(abs32(32'(err_now))) <= {2'h0, discrepancy_limit};
	assign delta = s.err - s.eprev;
	assign fb_low = fb_sel <= loss_threshold;
	assign loss_lim = 20'(loss_time) * `PPM_LOSS_TICKS;
	assign per_eff = (sample_period == 14'h0000) ? 14'h0001 : sample_period;
	assign ti_eff = (integral_period_constant == 10'h000) ? 10'h001 : integral_period_constant;
	assign isum_new = s.isum + 32'(err_now) * $signed({18'h0, per_eff});
	assign imax = $signed({22'h0, ti_eff}) * $signed({22'h0, `PPM_FULL_PCT});
	assign sum = s.p + s.i + s.d;

	// ----------------------------------------
	// shared restoring divider step
	// ----------------------------------------
	assign trial = {s.dr[15:0], s.dq[31]};
	assign ge = trial >= {1'b0, s.dd};
	assign qn = {s.dq[30:0], ge};
	assign qs = s.dneg ? -$signed(qn) : $signed(qn);
	assign done = s.dcnt == 5'h1F;

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		n = s;
		n.smp = 1'b0;
		tick = 1'b0;
		sample = 1'b0;
		ld = 1'b0;
		ld_val = 32'sh00000000;
		ld_dvs = 16'h0001;
		if (s.tcnt >= TICK_LAST) begin
			n.tcnt = 20'h00000;
			tick = 1'b1;
		end else begin
			n.tcnt = s.tcnt + 20'h00001;
		end
		if (tick) begin
			if (s.pcnt >= per_eff - 14'h0001) begin
				n.pcnt = 14'h0000;
				sample = 1'b1;
			end else begin
				n.pcnt = s.pcnt + 14'h0001;
			end
		end
		if (!fb_low) begin
			n.lcnt = 20'h00000;
		end else if (tick && s.lcnt != 20'hFFFFF) begin
			n.lcnt = s.lcnt + 20'h00001;
		end
		if (fault_clear) begin
			n.fault = 1'b0;
		end
		if (fb_low && s.lcnt > loss_lim) begin
			n.fault = 1'b1;
		end
		if (preset_write) begin
			n.pre[preset_index] = preset_value;
		end
		n.plvl = sat_pct(11'(abs32(32'($signed(s.pre[sel_idx])))));
		n.prev = s.pre[sel_idx][10];
		if (s.st != ppm_pkg::ST_IDLE && s.st != ppm_pkg::ST_SUM) begin
			n.dq = qn;
			n.dr = ge ? trial - {1'b0, s.dd} : trial;
			n.dcnt = s.dcnt + 5'h01;
		end
		case (s.st)
			ppm_pkg::ST_IDLE: begin
				if (sample) begin
					n.smp = 1'b1;
					n.err = err_now;
					n.eprev = s.err;
					if (!in_band) begin
						if (isum_new > imax) begin
							n.isum = imax;
						end else if (isum_new < -imax) begin
							n.isum = -imax;
						end else begin
							n.isum = isum_new;
						end
						ld = 1'b1;
						ld_val = 32'(err_now) * $signed({18'h0, proportional_gain});
						ld_dvs = `PPM_KP_FULL;
						n.st = ppm_pkg::ST_DP;
					end
				end
			end
			ppm_pkg::ST_DP: begin
				if (done) begin
					n.p = qs;
					ld = 1'b1;
					ld_val = s.isum;
					ld_dvs = {6'h00, ti_eff};
					n.st = ppm_pkg::ST_DI;
				end
			end
			ppm_pkg::ST_DI: begin
				if (done) begin
					n.i = qs;
					ld = 1'b1;
					ld_val = 32'(delta) * $signed({22'h0, derivative_period_constant});
					ld_dvs = {2'h0, per_eff};
					n.st = ppm_pkg::ST_DD;
				end
			end
			ppm_pkg::ST_DD: begin
				if (done) begin
					n.d = qs;
					n.st = ppm_pkg::ST_SUM;
				end
			end
			ppm_pkg::ST_SUM: begin
				if (sum[31]) begin
					n.u = 10'h000;
				end else if (sum > $signed({22'h0, `PPM_FULL_PCT})) begin
					n.u = `PPM_FULL_PCT;
				end else begin
					n.u = sum[9:0];
				end
				ld = 1'b1;
				ld_val = $signed({22'h0, n.u}) * $signed({16'h0, max_frequency});
				ld_dvs = {6'h00, `PPM_FULL_PCT};
				n.st = ppm_pkg::ST_DF;
			end
			ppm_pkg::ST_DF: begin
				if (done) begin
					n.freq = qn[15:0];
					n.st = ppm_pkg::ST_IDLE;
				end
			end
			default: begin
				n.st = ppm_pkg::ST_IDLE;
			end
		endcase
		if (ld) begin
			n.dq = abs32(ld_val);
			n.dneg = ld_val[31];
			n.dd = ld_dvs;
			n.dr = 17'h00000;
			n.dcnt = 5'h00;
		end
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			s <= '0;
			s.st <= ppm_pkg::ST_IDLE;
			s.dd <= 16'h0001;
			s.pre <= {8{`PPM_PRESET_RESET}};
		end else begin
			s <= n;
		end
	end

	assign freq_command = s.freq;
	assign feedback_loss_fault = s.fault;
	assign sample_strobe = s.smp;
	assign preset_level = s.plvl;
	assign preset_reverse = s.prev;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	AST_ERR_POS: assert property ((s.smp && !$past(output_polarity)) |->
		s.err == $signed({2'h0, $past(sp_sel)}) - $signed({2'h0, $past(fb_sel)}))
		else $error("positive polarity discrepancy wrong");
	AST_ERR_NEG: assert property ((s.smp && $past(output_polarity)) |->
		s.err == $signed({2'h0, $past(fb_sel)}) - $signed({2'h0, $past(sp_sel)}))
		else $error("negative polarity discrepancy wrong");
	AST_BAND_HOLD: assert property ((s.smp && $past(in_band)) |->
		s.st == ppm_pkg::ST_IDLE && $stable(s.isum) ##1 $stable(s.freq) [*8])
		else $error("output moved inside discrepancy limit");
	AST_CALC_BOUND: assert property ((s.st == ppm_pkg::ST_DP) |->
		##[1:200] (s.st == ppm_pkg::ST_IDLE))
		else $error("regulator run did not finish");
	AST_ONE_RUN: assert property (s.smp |=> !s.smp [*3])
		else $error("two runs in one period");
	AST_CLAMP: assert property ((s.st == ppm_pkg::ST_DF) |-> s.u <= `PPM_FULL_PCT)
		else $error("regulator output not clamped");
	AST_FREQ_SCALE: assert property (($past(s.st) == ppm_pkg::ST_DF && s.st == ppm_pkg::ST_IDLE) |->
		s.freq == 16'(({22'h0, s.u} * {16'h0, $past(max_frequency, 33)}) / 32'h000003E8))
		else $error("frequency scaling wrong");
	AST_FAULT_SET: assert property ((fb_low && s.lcnt > loss_lim) |=> s.fault)
		else $error("loss fault not raised");
	AST_FAULT_HOLD: assert property ((s.fault && !fault_clear) |=> s.fault)
		else $error("loss fault dropped without clear");
	AST_PRESET_REV: assert property (1'b1 |=> s.prev == $past(s.pre[sel_idx][10]))
		else $error("preset direction wrong");

	COV_RUN: cover property (s.st == ppm_pkg::ST_SUM ##[1:40] s.st == ppm_pkg::ST_IDLE);
	COV_HOLD: cover property (s.smp && s.st == ppm_pkg::ST_IDLE);
	COV_FAULT: cover property ($rose(s.fault));
	COV_REVERSE: cover property ($rose(s.prev));
endmodule : ppm_regulator
`default_nettype wire

// File: ppm_map.svh
/*
 offsets-free constant map of the process regulator: time base, scaling and defaults.
 assumes inclusion by bare name from the design file.
*/
`ifndef PPM_MAP_SVH
`define PPM_MAP_SVH
// ----------------------------------------
// timing
// ----------------------------------------
`define PPM_CLK_NS 10
`define PPM_TICK_NS 10000000
`define PPM_LOSS_TICKS 20'h0000A
// ----------------------------------------
// scaling
// ----------------------------------------
`define PPM_FULL_PCT 10'h3E8
`define PPM_KP_FULL 16'h2710
// ----------------------------------------
// configuration defaults
// ----------------------------------------
`define PPM_SP_SRC_DEFAULT 3'h0
`define PPM_FB_SRC_DEFAULT 2'h0
`define PPM_POL_DEFAULT 1'h0
`define PPM_KP_DEFAULT 14'h0064
`define PPM_TI_DEFAULT 10'h00A
`define PPM_TD_DEFAULT 10'h000
`define PPM_PERIOD_DEFAULT 14'h000A
`define PPM_LIMIT_DEFAULT 10'h000
`define PPM_LOSS_TIME_DEFAULT 16'h000A
`define PPM_PRESET_RESET 11'h000
`endif

// File: ppm_pkg.sv
/*
 types of the process regulator: sequencer states and the state record.
 assumes nothing beyond a SystemVerilog compiler.
*/
package ppm_pkg;
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_DP = 6'h02,
		ST_DI = 6'h04,
		ST_DD = 6'h08,
		ST_SUM = 6'h10,
		ST_DF = 6'h20
	} ppm_state_e;
	typedef struct packed {
		ppm_state_e st;
		logic [19:0] tcnt;
		logic [13:0] pcnt;
		logic [19:0] lcnt;
		logic fault;
		logic smp;
		logic signed [31:0] isum;
		logic signed [31:0] p;
		logic signed [31:0] i;
		logic signed [31:0] d;
		logic signed [11:0] err;
		logic signed [11:0] eprev;
		logic [31:0] dq;
		logic [16:0] dr;
		logic [15:0] dd;
		logic dneg;
		logic [4:0] dcnt;
		logic [9:0] u;
		logic [15:0] freq;
		logic [7:0][10:0] pre;
		logic [9:0] plvl;
		logic prev;
	} ppm_state_s;
endpackage : ppm_pkg

// File: ppm_sensor_model.sv
/*
 far-side model: analog feedback sensors, comm feedback and speed-select terminals.
 assumes the bench requests levels; they appear one clock later.
*/
`timescale 1ns/1ps
`default_nettype none
module ppm_sensor_model (
	input wire logic clk,
	input wire logic [9:0] req_v,
	input wire logic [9:0] req_c,
	input wire logic [9:0] req_m,
	input wire logic [2:0] req_sel,
	output logic [9:0] voltage_analog_input,
	output logic [9:0] current_analog_input,
	output logic [9:0] comm_feedback,
	output logic speed_select_bit0,
	output logic speed_select_bit1,
	output logic speed_select_bit2
);
	// ----------------------------------------
	// sensor and terminal levels
	// ----------------------------------------
	always_ff @(posedge clk) begin
		voltage_analog_input <= req_v;
		current_analog_input <= req_c;
		comm_feedback <= req_m;
		{speed_select_bit2, speed_select_bit1, speed_select_bit0} <= req_sel;
	end
endmodule : ppm_sensor_model
`default_nettype wire

// File: testbench.sv
/*
 self-checking bench of the process regulator with a reference model.
 assumes ppm_regulator and ppm_sensor_model; tick shortened to 10 clocks.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [2:0] ss = 3'h0;
	logic [1:0] fs = 2'h0;
	logic pol = 1'b0;
	logic [9:0] sp = 10'h000, csp = 10'h000, ti = 10'h00A, td = 10'h000, lim = 10'h000;
	logic [9:0] thr = 10'h000, rv = 10'h000, rc = 10'h000, rm = 10'h000;
	logic [13:0] kp = 14'h0064, per = 14'h000E;
	logic [15:0] lt = 16'h8CA0, mx = 16'h2710;
	logic pw = 1'b0, fc = 1'b0;
	logic [2:0] pidx = 3'h0, rsel = 3'h0;
	logic [10:0] pval = 11'h000;
	logic [9:0] v, c, m, plv;
	logic s0, s1, s2, flt, stb, prv;
	logic [15:0] fq;
	int num_errors = 0, samples_checked = 0;
	int pre[8], isum, ep, ef, gap, f, s, e, u, i, k;
	always #5 clk = ~clk;
	ppm_sensor_model u_ppm_sensor_model (.clk(clk), .req_v(rv), .req_c(rc), .req_m(rm),
		.req_sel(rsel), .voltage_analog_input(v), .current_analog_input(c), .comm_feedback(m),
		.speed_select_bit0(s0), .speed_select_bit1(s1), .speed_select_bit2(s2));
	ppm_regulator #(.TICK_CYCLES(10)) u_ppm_regulator (.clk(clk), .rst(rst),
		.setpoint_source(ss), .feedback_source(fs), .output_polarity(pol),
		.keypad_setpoint(sp), .voltage_analog_input(v), .current_analog_input(c),
		.comm_setpoint(csp), .comm_feedback(m), .proportional_gain(kp),
		.integral_period_constant(ti), .derivative_period_constant(td), .sample_period(per),
		.discrepancy_limit(lim), .loss_threshold(thr), .loss_time(lt), .max_frequency(mx),
		.speed_select_bit0(s0), .speed_select_bit1(s1), .speed_select_bit2(s2),
		.preset_write(pw), .preset_index(pidx), .preset_value(pval), .fault_clear(fc),
		.freq_command(fq), .feedback_loss_fault(flt), .sample_strobe(stb),
		.preset_level(plv), .preset_reverse(prv));
	// ----------------------------------------
	// checking and reference model
	// ----------------------------------------
	task chk(input string n, input logic [15:0] seen, input logic [15:0] want);
		samples_checked++;
		if (seen !== want) begin
			num_errors++;
			$display("mismatch %s expected %0h seen %0h", n, want, seen);
		end
	endtask : chk
	task end_of_test;
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : end_of_test
	task run(input string n);
		int j;
		for (j = 0; j < 300 && stb !== 1'b1; j++) begin
			@(posedge clk);
			#1;
		end
		if (j == 300) begin
			num_errors++;
			end_of_test();
		end
		repeat (131) @(posedge clk);
		#1 chk(n, fq, 16'(ef));
	endtask : run
	task go(input string n, input int a, input int b, input int p, input int x, input int y);
		@(posedge clk);
		ss <= 3'(a);
		fs <= 2'(b);
		pol <= 1'(p);
		sp <= 10'(x);
		rv <= 10'(y);
		run(n);
	endtask : go
	always @(negedge clk) begin
		if (rst) begin
			isum = 0;
			ep = 0;
			ef = 0;
			gap = -1;
		end else begin
			if (gap >= 0) gap++;
			if (stb === 1'b1) begin
				if (gap > 0) chk("sample_gap", 16'(gap), 16'h008C);
				gap = 0;
				f = fs == 0 ? v : fs == 1 ? c : fs == 2 ? ((v + c > 1000) ? 1000 : v + c) : m;
				k = pre[{s2, s1, s0}];
				s = ss == 1 ? c * 0 + v : ss == 2 ? c : ss == 3 ? csp : ss == 4 ? (k < 0 ? 0 : k) : sp;
				e = pol ? f - s : s - f;
				if ((e < 0 ? -e : e) > int'(lim)) begin
					isum += e * int'(per);
					if (isum > 1000 * int'(ti)) isum = 1000 * int'(ti);
					if (isum < -1000 * int'(ti)) isum = -1000 * int'(ti);
					u = e * int'(kp) / 10000 + isum / int'(ti) + (e - ep) * int'(td) / int'(per);
					u = u < 0 ? 0 : u > 1000 ? 1000 : u;
					ef = u * int'(mx) / 1000;
				end
				ep = e;
			end
		end
	end
	// ----------------------------------------
	// test sequence
	// ----------------------------------------
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1 chk("freq_rst", fq, 16'h0000);
		chk("level_rst", {flt, prv, 4'h0, plv}, 16'h0000);
		for (i = 0; i < 8; i++) begin
			@(posedge clk);
			pre[i] = i * 250 - 900;
			pw <= 1'b1;
			pidx <= 3'(i);
			pval <= 11'(pre[i]);
		end
		@(posedge clk);
		pw <= 1'b0;
		for (i = 0; i < 8; i++) begin
			@(posedge clk);
			rsel <= 3'(i);
			repeat (4) @(posedge clk);
			#1 chk("preset_level", {6'h00, plv}, 16'(pre[i] < 0 ? -pre[i] : pre[i]));
			chk("preset_reverse", 16'(prv), 16'(pre[i] < 0));
		end
		run("freq_idle");
		@(posedge clk);
		kp <= 14'h2710;
		ti <= 10'h3E8;
		go("p_full", 0, 0, 0, 500, 0);
		go("i_grows", 0, 0, 0, 500, 0);
		go("neg_pol", 0, 0, 1, 500, 800);
		go("pos_pol", 0, 0, 0, 500, 800);
		@(posedge clk);
		rc <= 10'h0C8;
		rm <= 10'h12C;
		for (i = 0; i < 4; i++) go("fb_src", 0, i, 0, 900, 100);
		@(posedge clk);
		csp <= 10'h320;
		rc <= 10'h2BC;
		for (i = 1; i < 5; i++) go("sp_src", i, i == 1, 0, 0, 100);
		@(posedge clk);
		lim <= 10'h3E8;
		go("in_band", 0, 0, 0, 100, 900);
		@(posedge clk);
		lim <= 10'h000;
		td <= 10'h001;
		kp <= 14'h0000;
		go("deriv_step", 0, 0, 0, 900, 0);
		go("deriv_flat", 0, 0, 0, 900, 0);
		@(posedge clk);
		mx <= 16'h1234;
		go("max_scale", 0, 0, 0, 1000, 600);
		@(posedge clk);
		thr <= 10'h064;
		lt <= 16'h0002;
		rv <= 10'h032;
		repeat (150) @(posedge clk);
		#1 chk("fault_early", 16'(flt), 16'h0000);
		for (i = 0; i < 150 && flt !== 1'b1; i++) begin
			@(posedge clk);
			#1;
		end
		chk("fault_set", 16'(flt), 16'h0001);
		@(posedge clk);
		fc <= 1'b1;
		@(posedge clk);
		fc <= 1'b0;
		repeat (2) @(posedge clk);
		#1 chk("fault_sticky", 16'(flt), 16'h0001);
		@(posedge clk);
		rv <= 10'h3E8;
		repeat (3) @(posedge clk);
		fc <= 1'b1;
		@(posedge clk);
		fc <= 1'b0;
		repeat (2) @(posedge clk);
		#1 chk("fault_clear", 16'(flt), 16'h0000);
		end_of_test();
	end
endmodule : testbench
`default_nettype wire
